// File: src/tse_event_ctrl.sv
/*
  Two-stage event controller: a router that ORs peripheral sources onto
  general levels, and a core stage with latch, mask and pending vectors
  that picks, nests and returns events.
  Assumes the pipeline signals ready, return and pc on clock_i; the
  peripheral lines and the nonmaskable pin are asynchronous.
*/
// Functional notes
// - Several handlers may nest at once
// - Higher priority served first, preempts lower
// - Five classes: emulation, reset, NMI, exception, interrupt
// - Emulation event enters emulation mode
// - Accepted reset event resets the processor
// - NMI from watchdog or external pin
// - Exceptions are synchronous, taken before completion
// - Interrupts asynchronous: pins, peripherals, software
// - Each class has own return address
// - State pushed to supervisor stack on entry
// - Peripheral lines go through router to general levels
// - Nine general levels, seven to fifteen
// - Fixed priority order, level 4 reserved
// - Default routing, software may reassign levels
// - Default: wake-up, errors 7; clock, parallel 8
// - Default: serial port DMA to level 9
// - Default: SPI and UART DMA to 10
// - Default: timers, two-wire, CAN to 11
// - Default: GPIO A and B to 12
// - Default: memory DMA, watchdog to 13
// - Control writes only in supervisor mode
// - Rising edge latches; pending set clears latch
// - Masked events stay latched, not serviced
// - Per-source status shows asserting sources
`timescale 1ns/100ps
`default_nettype none

module tse_event_ctrl
  import tse_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [`TSE_N_SRC-1:0] src_irq_i,
  input wire logic nmi_pin_i,
  input wire logic emu_req_i,
  input wire logic rst_req_i,
  input wire logic wdog_nmi_i,
  input wire logic exc_req_i,
  input wire logic hwerr_i,
  input wire logic ctmr_i,
  input wire tse_raise_s raise_i,
  input wire logic sup_i,
  input wire tse_asg_s asg_i,
  input wire tse_vwr_s mask_wr_i,
  input wire tse_vwr_s lclr_i,
  input wire logic ready_i,
  input wire logic ret_i,
  input wire logic [`TSE_PC_W-1:0] pc_i,
  output logic take_o,
  output tse_lvl_t take_lvl_o,
  output logic push_o,
  output logic emu_mode_o,
  output logic core_reset_o,
  output logic ret_done_o,
  output logic [`TSE_PC_W-1:0] ret_pc_o,
  output tse_vec_t latch_o,
  output tse_vec_t mask_o,
  output tse_vec_t pend_o,
  output logic [`TSE_N_SRC-1:0] status_o
);

  // ****************************************
  // State and combinational helpers
  // ****************************************
  localparam tse_map_t DFLT_MAP = tse_dflt_map();

  tse_state_s s;
  tse_state_s next_s;
  tse_vec_t src_oh [`TSE_N_SRC];
  tse_vec_t route;
  tse_vec_t raw;
  tse_vec_t edge_v;
  tse_vec_t eff_mask;
  tse_vec_t lclr;
  tse_vec_t taken;
  logic found;
  logic blk;
  tse_lvl_t sel;
  logic have_pend;
  tse_lvl_t cur;

  // Each synchronised source drives a one-hot vector of its level
  genvar g;
  for (g = 0; g < `TSE_N_SRC; g++) begin : g_src
    assign src_oh[g] = s.s2[g] ? (tse_vec_t'(1) << s.amap[g]) : '0;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.take = 1'b0;
    next_s.push = 1'b0;
    next_s.core_reset = 1'b0;
    next_s.ret_done = 1'b0;

    // Pins pass two flops before anyone looks at them
    next_s.s1 = src_irq_i;
    next_s.s2 = s.s1;
    next_s.nmi1 = nmi_pin_i;
    next_s.nmi2 = s.nmi1;

    // Reassignment only from supervisor, only onto general levels
    if (asg_i.en && sup_i && asg_i.idx < `TSE_IDX_W'(`TSE_N_SRC)
        && asg_i.lvl >= tse_lvl_t'(`TSE_LVL_GEN_LO)) begin
      next_s.amap[asg_i.idx] = asg_i.lvl;
    end

    // OR all sources that share a level
    route = '0;
    for (int k = 0; k < `TSE_N_SRC; k++) begin
      route = route | src_oh[k];
    end

    // Raw request per priority level
    raw = '0;
    raw[`TSE_LVL_EMU] = emu_req_i;
    raw[`TSE_LVL_RST] = rst_req_i;
    raw[`TSE_LVL_NMI] = s.nmi2 | wdog_nmi_i;
    raw[`TSE_LVL_EXC] = exc_req_i;
    raw[`TSE_LVL_HWE] = hwerr_i;
    raw[`TSE_LVL_TMR] = ctmr_i;
    raw[`TSE_LVL_GEN_HI:`TSE_LVL_GEN_LO] = route[`TSE_LVL_GEN_HI:`TSE_LVL_GEN_LO];
    if (raise_i.en && raise_i.lvl >= tse_lvl_t'(`TSE_LVL_GEN_LO)) begin
      raw[raise_i.lvl] = 1'b1;
    end
    next_s.raw_q = raw;
    edge_v = raw & ~s.raw_q & ~`TSE_RSVD_BITS;

    // Top four events can never be masked; reserved level never exists
    eff_mask = s.mask | `TSE_FIXED_MASK;
    if (mask_wr_i.en && sup_i) begin
      next_s.mask = mask_wr_i.data & ~`TSE_FIXED_MASK & ~`TSE_RSVD_BITS;
    end
    // Cancelling a latched event is allowed only while it is masked
    lclr = (lclr_i.en && sup_i) ? (lclr_i.data & ~eff_mask) : '0;

    // Scan from level 0 down; a pending level blocks itself and below
    found = 1'b0;
    blk = 1'b0;
    sel = '0;
    for (int i = 0; i < `TSE_N_LVL; i++) begin
      if (s.pend[i]) begin
        blk = 1'b1;
      end else if (!blk && s.latch[i] && eff_mask[i]) begin
        found = 1'b1;
        sel = tse_lvl_t'(i);
        blk = 1'b1;
      end
    end

    // Lowest pending index is the handler now running
    have_pend = 1'b0;
    cur = '0;
    for (int i = `TSE_N_LVL - 1; i >= 0; i--) begin
      if (s.pend[i]) begin
        have_pend = 1'b1;
        cur = tse_lvl_t'(i);
      end
    end

    // Accept: nest on top of the running handler and push state
    taken = '0;
    if (found && ready_i && !ret_i) begin
      taken = tse_vec_t'(1) << sel;
      next_s.pend = s.pend | taken;
      next_s.take = 1'b1;
      next_s.take_lvl = sel;
      next_s.push = 1'b1;
      next_s.ret_addr[tse_class(sel)] = pc_i;
      if (sel == tse_lvl_t'(`TSE_LVL_EMU)) begin
        next_s.emu_mode = 1'b1;
      end
      if (sel == tse_lvl_t'(`TSE_LVL_RST)) begin
        next_s.core_reset = 1'b1;
      end
    end else if (ret_i && have_pend) begin
      // Return unwinds the innermost handler through its class slot
      next_s.pend[cur] = 1'b0;
      next_s.ret_done = 1'b1;
      next_s.ret_pc = s.ret_addr[tse_class(cur)];
      if (cur == tse_lvl_t'(`TSE_LVL_EMU)) begin
        next_s.emu_mode = 1'b0;
      end
    end

    // A fresh edge wins over any clear in the same cycle
    next_s.latch = (s.latch & ~lclr & ~taken) | edge_v;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.amap <= DFLT_MAP;
      s.mask <= `TSE_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign take_o = s.take;
  assign take_lvl_o = s.take_lvl;
  assign push_o = s.push;
  assign emu_mode_o = s.emu_mode;
  assign core_reset_o = s.core_reset;
  assign ret_done_o = s.ret_done;
  assign ret_pc_o = s.ret_pc;
  assign latch_o = s.latch;
  assign mask_o = s.mask;
  assign pend_o = s.pend;
  assign status_o = s.s2;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence seq_take;
    s.take;
  endsequence

  sequence seq_rst_pulse;
    s.core_reset ##1 !s.core_reset;
  endsequence

  take_nest_a: assert property (
    seq_take |-> s.pend == ($past(s.pend) | (tse_vec_t'(1) << s.take_lvl)))
    else $error("nested accept changed other pending bits");

  take_prio_a: assert property (
    seq_take |-> ($past(s.pend) & ((tse_vec_t'(2) << s.take_lvl) - tse_vec_t'(1))) == '0)
    else $error("accepted level not above every pending level");

  emu_mode_a: assert property (
    seq_take and (s.take_lvl == tse_lvl_t'(`TSE_LVL_EMU)) |-> s.emu_mode)
    else $error("emulation accept did not enter emulation mode");

  core_rst_a: assert property (
    seq_take and (s.take_lvl == tse_lvl_t'(`TSE_LVL_RST)) |-> seq_rst_pulse)
    else $error("reset accept did not give one-cycle core reset");

  // Either the watchdog or the synchronised pin must latch level 2 one edge later
  nmi_src_a: assert property (
    $rose(raw[`TSE_LVL_NMI]) |=> s.latch[`TSE_LVL_NMI])
    else $error("nonmaskable request not latched");

  ret_slot_a: assert property (
    seq_take |-> s.ret_addr[tse_class(s.take_lvl)] == $past(pc_i))
    else $error("return address not saved in class slot");

  push_a: assert property (
    seq_take |-> s.push ##1 !s.push || s.take)
    else $error("state push missing on accept");

  level_edge_a: assert property (
    $rose(s.s2[0]) && !s.raw_q[s.amap[0]] |-> ##[1:2] (s.latch[s.amap[0]] || s.pend[s.amap[0]]))
    else $error("routed edge did not reach latch");

  mask_gate_a: assert property (
    seq_take |-> ($past(eff_mask) & (tse_vec_t'(1) << s.take_lvl)) != '0)
    else $error("masked event was serviced");

  sup_only_a: assert property (
    !sup_i |=> $stable(s.mask) && $stable(s.amap))
    else $error("control changed outside supervisor mode");

  status_a: assert property (
    $rose(src_irq_i[0]) |-> ##2 status_o[0])
    else $error("source status lags more than two cycles");

  // Return always drops exactly the innermost (lowest numbered) pending bit
  ret_unwind_a: assert property (
    s.ret_done |-> s.pend == ($past(s.pend) & ($past(s.pend) - tse_vec_t'(1))))
    else $error("return did not unwind the innermost handler");

  latch_clear_a: assert property (
    seq_take |-> (s.latch & ~$past(edge_v) & (tse_vec_t'(1) << s.take_lvl)) == '0)
    else $error("accepted event still latched");

  emu_exit_a: assert property (
    s.ret_done && $fell(s.pend[`TSE_LVL_EMU]) |-> !s.emu_mode)
    else $error("emulation mode kept after its return");

  // A stalled or returning pipeline must never see an accept
  take_gate_a: assert property (
    seq_take |-> $past(ready_i) && !$past(ret_i))
    else $error("event accepted while pipeline refused");

endmodule

`default_nettype wire

// File: src/tse_map.svh
/*
  Constants of the two-stage event controller: sizes, event levels,
  default routing boundaries and fixed mask bits.
  Assumes inclusion by the package and the design module only.
*/
`ifndef TSE_MAP_SVH
`define TSE_MAP_SVH

// ****************************************
// Sizes
// ****************************************
`define TSE_N_SRC 48
`define TSE_N_LVL 16
`define TSE_N_CLASS 5
`define TSE_PC_W 32
`define TSE_IDX_W 6

// ****************************************
// Fixed event levels, 0 is highest
// ****************************************
`define TSE_LVL_EMU 0
`define TSE_LVL_RST 1
`define TSE_LVL_NMI 2
`define TSE_LVL_EXC 3
`define TSE_LVL_RSVD 4
`define TSE_LVL_HWE 5
`define TSE_LVL_TMR 6
`define TSE_LVL_GEN_LO 7
`define TSE_LVL_GEN_HI 15

// ****************************************
// Default routing: source index below each end maps to that level
// ****************************************
`define TSE_END_L7 15
`define TSE_END_L8 17
`define TSE_END_L9 25
`define TSE_END_L10 34
`define TSE_END_L11 41
`define TSE_END_L12 43

// ****************************************
// Mask layout and reset values
// ****************************************
`define TSE_FIXED_MASK 16'h000F
`define TSE_RSVD_BITS 16'h0010
`define TSE_MASK_RST 16'h0000

`endif

// File: src/tse_pkg.sv
/*
  Types of the two-stage event controller: state struct, carrier
  structs and the default routing table builder.
  Assumes tse_map.svh is on the include path.
*/
`include "tse_map.svh"

package tse_pkg;

  typedef logic [3:0] tse_lvl_t;
  typedef logic [`TSE_N_LVL-1:0] tse_vec_t;
  typedef tse_lvl_t [`TSE_N_SRC-1:0] tse_map_t;

  // Write of one source's level
  typedef struct packed {
    logic en;
    logic [`TSE_IDX_W-1:0] idx;
    tse_lvl_t lvl;
  } tse_asg_s;

  // Write of a whole event vector (mask load or latch cancel)
  typedef struct packed {
    logic en;
    tse_vec_t data;
  } tse_vwr_s;

  // Software raise of one general level
  typedef struct packed {
    logic en;
    tse_lvl_t lvl;
  } tse_raise_s;

  typedef struct packed {
    tse_map_t amap;
    logic [`TSE_N_SRC-1:0] s1;
    logic [`TSE_N_SRC-1:0] s2;
    logic nmi1;
    logic nmi2;
    tse_vec_t raw_q;
    tse_vec_t latch;
    tse_vec_t mask;
    tse_vec_t pend;
    logic [`TSE_N_CLASS-1:0][`TSE_PC_W-1:0] ret_addr;
    logic take;
    tse_lvl_t take_lvl;
    logic push;
    logic emu_mode;
    logic core_reset;
    logic ret_done;
    logic [`TSE_PC_W-1:0] ret_pc;
  } tse_state_s;

  // Event class: fixed levels up to and including the exception keep their own slot
  function automatic logic [2:0] tse_class(tse_lvl_t l);
    if (l <= tse_lvl_t'(`TSE_LVL_EXC)) begin
      return l[2:0];
    end
    return 3'(`TSE_N_CLASS - 1);
  endfunction

  // Default source-to-level table
  function automatic tse_map_t tse_dflt_map();
    tse_map_t m;
    int c;
    for (int i = 0; i < `TSE_N_SRC; i++) begin
      c = int'(i >= `TSE_END_L7) + int'(i >= `TSE_END_L8) + int'(i >= `TSE_END_L9)
        + int'(i >= `TSE_END_L10) + int'(i >= `TSE_END_L11) + int'(i >= `TSE_END_L12);
      m[i] = tse_lvl_t'(`TSE_LVL_GEN_LO + c);
    end
    return m;
  endfunction

endpackage

// File: test/tb_two_stage_event_controller.sv
/*
  Bench of the event controller: drives sources, requests and writes,
  queues expected accept levels and return addresses, checks them.
  Assumes the package, the design and the pipeline model come first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_two_stage_event_controller
  import tse_pkg::*;
;
  // ****************
  // Bench
  // ****************
  logic clock_i = 1'b0, rst_i = 1'b1, sup = 1'b1;
  logic [47:0] src = '0, stat;
  logic [6:0] fx = '0;
  tse_raise_s raise = '0;
  tse_asg_s asg = '0;
  tse_vwr_s mw = '0, lc = '0;
  logic ready, ret, take, push, emulation_event, crst, rdone;
  logic [31:0] pc, rpc;
  tse_lvl_t tlvl, l;
  tse_vec_t lat, msk, pnd;
  int fails = 0, samples_checked = 0, tk = 0, rn = 0;
  integer seed = 32'h0c5e_2b2a;
  tse_lvl_t exp_lvl [$];
  logic [31:0] exp_pc [$];
  tse_lvl_t flv [7] = '{0, 1, 2, 3, 5, 6, 2};
  int ends [6] = '{15, 17, 25, 34, 41, 43};

  always #2 clock_i = ~clock_i;

  tse_event_ctrl i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .src_irq_i(src), .nmi_pin_i(fx[6]),
    .emu_req_i(fx[0]), .rst_req_i(fx[1]), .wdog_nmi_i(fx[2]), .exc_req_i(fx[3]),
    .hwerr_i(fx[4]), .ctmr_i(fx[5]), .raise_i(raise), .sup_i(sup), .asg_i(asg),
    .mask_wr_i(mw), .lclr_i(lc), .ready_i(ready), .ret_i(ret), .pc_i(pc),
    .take_o(take), .take_lvl_o(tlvl), .push_o(push), .emu_mode_o(emulation_event),
    .core_reset_o(crst), .ret_done_o(rdone), .ret_pc_o(rpc), .latch_o(lat),
    .mask_o(msk), .pend_o(pnd), .status_o(stat)
  );

  tse_pipe_model i_pipe (
    .clock_i(clock_i), .rst_i(rst_i), .take_i(take), .take_lvl_i(tlvl), .ret_done_i(rdone),
    .ready_o(ready), .ret_o(ret), .pc_o(pc)
  );

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Every drive lands one time unit after a rising edge
  task automatic cyc(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Bounded wait for the next accept
  task automatic wtake();
    int k;
    tk++;
    for (k = 0; k < 200 && i_pipe.n_take < tk; k++) cyc(1);
    chk(i_pipe.n_take, tk);
  endtask

  // Return answers on the next cycle, so no wait loop is needed
  task automatic rett();
    i_pipe.ret1();
    rn++;
    cyc(1);
    chk(i_pipe.n_ret, rn);
  endtask

  task automatic sw(tse_lvl_t v);
    raise = '{1'b1, v};
    cyc(1);
    raise = '0;
    cyc(1);
  endtask

  // One write cycle of mask, cancel and assignment under a given mode
  task automatic wr(tse_vwr_s m, tse_vwr_s c, tse_asg_s a, logic s);
    sup = s;
    mw = m;
    lc = c;
    asg = a;
    cyc(1);
    mw = '0;
    lc = '0;
    asg = '0;
    sup = 1'b1;
    cyc(1);
  endtask

  // Pulse one source and serve the level it reaches
  task automatic fire(int i, tse_lvl_t v);
    exp_lvl.push_back(v);
    src[i] = 1'b1;
    cyc(3);
    chk(stat, src);
    wtake();
    chk(lat, '0);
    src[i] = 1'b0;
    rett();
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge clock_i) begin
    if (take === 1'b1) begin
      chk(exp_lvl.size() != 0, 1'b1);
      chk(tlvl, exp_lvl.pop_front());
      chk(push, 1'b1);
      chk(crst, tlvl == 4'h1);
    end
    if (rdone === 1'b1) begin
      chk(exp_pc.size() != 0, 1'b1);
      chk(rpc, exp_pc.pop_front());
    end
  end

  initial begin
    cyc(4);
    rst_i = 1'b0;
    chk({take, push, emulation_event, crst, rdone}, '0);
    chk({lat, msk, pnd}, '0);
    // Random cancel and remap outside supervisor mode must change nothing
    wr('{1'b1, 16'hFFFF}, tse_vwr_s'({1'b1, 16'($random(seed))}),
      tse_asg_s'({1'b1, 6'($random(seed) & 31), 4'hF}), 1'b0);
    chk(msk, '0);
    wr('{1'b1, 16'hFFFF}, '0, '0, 1'b1);
    chk(msk, 16'hFFE0);
    for (int i = 0; i < 7; i++) begin
      exp_lvl.push_back(flv[i]);
      fx = 7'(1) << i;
      cyc(1);
      fx = '0;
      wtake();
      chk(emulation_event, i == 0);
      rett();
      chk(emulation_event, 1'b0);
    end
    for (int i = 0; i < 48; i++) begin
      l = 4'h7;
      foreach (ends[k]) l += tse_lvl_t'(i >= ends[k]);
      fire(i, l);
    end
    exp_lvl.push_back(4'h7);
    src[3:2] = 2'b11;
    wtake();
    src = '0;
    rett();
    cyc(6);
    chk(i_pipe.n_take, tk);
    wr('0, '0, '{1'b1, 6'h00, 4'hD}, 1'b0);
    wr('0, '0, '{1'b1, 6'h01, 4'h3}, 1'b1);
    fire(0, 4'h7);
    fire(1, 4'h7);
    wr('0, '0, '{1'b1, 6'h00, 4'hD}, 1'b1);
    fire(0, 4'hD);
    wr('{1'b1, 16'hEDE0}, '0, '0, 1'b1);
    sw(4'hC);
    sw(4'h9);
    chk(lat, 16'h1200);
    chk(i_pipe.n_take, tk);
    exp_lvl.push_back(4'h9);
    exp_lvl.push_back(4'hC);
    wr('{1'b1, 16'hFFFF}, '0, '0, 1'b1);
    wtake();
    rett();
    wtake();
    exp_lvl.push_back(4'hA);
    sw(4'hA);
    wtake();
    chk(pnd, 16'h1400);
    exp_lvl.push_back(4'hE);
    sw(4'hE);
    cyc(3);
    chk(lat, 16'h4000);
    rett();
    rett();
    wtake();
    rett();
    wr('{1'b1, 16'hFBFF}, '0, '0, 1'b1);
    sw(4'hA);
    chk(lat, 16'h0400);
    wr('0, '{1'b1, 16'h0400}, '0, 1'b1);
    chk(lat, '0);
    wr('{1'b1, 16'hFFFF}, '0, '0, 1'b1);
    exp_lvl.push_back(4'h9);
    sw(4'h9);
    wtake();
    // Reset in mid-handler: everything clears and the map returns to default
    rst_i = 1'b1;
    cyc(2);
    rst_i = 1'b0;
    chk({lat, msk, pnd}, '0);
    chk({take, push, emulation_event, crst, rdone}, '0);
    wr('{1'b1, 16'hFFFF}, '0, '0, 1'b1);
    fire(0, 4'h7);
    chk(exp_lvl.size() + exp_pc.size(), 0);
    print_verdict();
  end

  // Hang guard at 10000 cycles, far beyond the several hundred cycles the run needs
  initial begin
    #40000;
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire

// File: test/tse_pipe_model.sv
/*
  Pipeline model: random stalls, a new address each cycle, one saved
  address per class. Assumes the bench top owns the queue exp_pc.
*/
`timescale 1ns/100ps
`default_nettype none

module tse_pipe_model
  import tse_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic take_i,
  input wire tse_lvl_t take_lvl_i,
  input wire logic ret_done_i,
  output logic ready_o,
  output logic ret_o,
  output logic [31:0] pc_o
);
  // ****************
  // Pipeline model
  // ****************
  integer seed = 32'h0c5e_2b2a;
  int n_take = 0, n_ret = 0, c;
  logic [31:0] hold = '0;
  logic [31:0] slot [5];
  tse_vec_t pend = '0;

  initial begin
    ready_o = 1'b0;
    ret_o = 1'b0;
    pc_o = '0;
  end

  // Accepts are booked first, so a return sees the accept of the edge before
  always @(posedge clock_i) begin
    // Reset forgets every nested handler, just as the controller does
    if (rst_i === 1'b1) begin
      pend = '0;
    end
    if (take_i === 1'b1) begin
      n_take++;
      c = (take_lvl_i < 4) ? int'(take_lvl_i) : 4;
      slot[c] = hold;
      pend[take_lvl_i] = 1'b1;
    end
    n_ret += int'(ret_done_i === 1'b1);
    if (ret_o && pend != '0) begin
      for (c = 0; !pend[c]; c++) begin
      end
      pend[c] = 1'b0;
      tb_two_stage_event_controller.exp_pc.push_back(slot[(c < 4) ? c : 4]);
    end
    hold = pc_o;
    #1;
    ready_o = ($random(seed) & 3) != 0; // Slow answers: a stall one cycle in four
    pc_o = $random(seed);
  end

  // Return request held for exactly one sampling edge
  task automatic ret1();
    @(posedge clock_i);
    #1 ret_o = 1'b1;
    @(posedge clock_i);
    #1 ret_o = 1'b0;
  endtask
endmodule
`default_nettype wire
